// *** clock_switch_map.vh ***
// constants for the clock switch and pre-divider block
`ifndef CLOCK_SWITCH_MAP_VH
`define CLOCK_SWITCH_MAP_VH

// clock configuration build options
`define CFG_DUAL 2'h0
`define CFG_SLOW_ONLY 2'h1
`define CFG_FAST_ONLY 2'h2

// pre-divider input select for the fast-only build
`define PREDIV_IN_DIV_1 2'h0
`define PREDIV_IN_DIV_4 2'h1
`define PREDIV_IN_DIV_8 2'h2
`define PREDIV_IN_DIV_16 2'h3

// switch-over hold lengths, in oscillator cycles
`define FAST_HOLD_CYCLES 4'hc
`define SLOW_HOLD_CYCLES 4'h2

// operand of the pending-clear instruction that clears the upper stages
`define PENDING_CLEAR_OPERAND 12'h100

// pre-divider geometry
`define PREDIV_STAGES 15
`define PREDIV_CLEAR_LSB 10
`define PREDIV_STAGE14_BIT 13

// apb register byte offsets
`define REG_STATUS 12'h000
`define REG_MASK 12'h004
`define REG_STATE 12'h008
`define REG_BOOST 12'h00c
`define REG_PREDIV 12'h010

// status and mask bit positions
`define ST_PREDIV_EVENT 0
`define ST_HALT_RELEASE 1
`define ST_SWITCH_DONE 2
`define ST_WIDTH 3

// state register bit positions
`define SV_FAST_SELECTED 0
`define SV_HOLDING 1
`define SV_REQUEST_FLAG 2
`define SV_START_FLAG 3
`define SV_BOOST 4
`define SV_FAST_OSC_ON 5
`define SV_SLOW_OSC_ON 6

// reset values
`define STATUS_RESET 3'h0
`define MASK_RESET 3'h0
`define BOOST_RESET_DEFAULT 1'b1

`endif

// *** predivider_counter.v ***
// fifteen-stage pre-divider counter with stage-fourteen falling edge event
`timescale 1ns/10ps
`include "clock_switch_map.vh"

module predivider_counter #(
  parameter STAGES = `PREDIV_STAGES
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // control
  input wire input_fall,
  input wire clear_upper,
  // results
  output reg [STAGES-1:0] count_reg,
  output reg stage14_fall_reg
);

  reg [STAGES-1:0] count_next;
  integer i;

  //////////////////////////////////////////////////////////////////////////
  // advance on falling input edge; upper stages forced to zero on clear
  always @* begin
    count_next = count_reg;
    if (input_fall) begin
      count_next = count_reg + {{(STAGES-1){1'b0}}, 1'b1};
    end
    if (clear_upper) begin
      for (i = `PREDIV_CLEAR_LSB; i < STAGES; i = i + 1) begin
        count_next[i] = 1'b0;
      end
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      count_reg <= {STAGES{1'b0}};
      stage14_fall_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      // a clear that drops stage fourteen also counts as its falling edge
      stage14_fall_reg <= count_reg[`PREDIV_STAGE14_BIT] &
                          ~count_next[`PREDIV_STAGE14_BIT];
    end
  end

endmodule

// *** clock_switch.v ***
// clock switch, switch-over hold, pre-divider events and apb registers
`timescale 1ns/10ps
`include "clock_switch_map.vh"

module clock_switch #(
  parameter [1:0] CLOCK_CONFIG = `CFG_DUAL,
  parameter [1:0] PREDIV_INPUT_DIVIDE = `PREDIV_IN_DIV_1,
  parameter BOOST_RESET = `BOOST_RESET_DEFAULT
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // oscillator pins
  input wire slow_oscillator_clock,
  input wire fast_oscillator_clock,
  output reg slow_oscillator_enable_reg,
  output reg fast_oscillator_enable_reg,
  // processor core commands and modes
  input wire fast_instruction,
  input wire slow_instruction,
  input wire stop_instruction,
  input wire halt_mode,
  input wire stop_mode,
  input wire pending_clear_instruction,
  input wire [11:0] pending_clear_operand,
  input wire predivider_interrupt_enable,
  input wire predivider_halt_release_enable,
  input wire request_flag_clear,
  input wire start_flag_clear,
  // clocks and events to the core and peripherals
  output reg system_clock_reg,
  output reg system_clock_hold_reg,
  output reg predivider_input_clock_reg,
  output reg [`PREDIV_STAGES-1:0] predivider_taps_reg,
  output reg predivider_release_request_flag,
  output reg predivider_interrupt_request_reg,
  output reg halt_release_request_reg,
  output reg predivider_start_condition_flag,
  output reg oscillator_boost_flag,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  output reg irq_reg
);

  localparam [3:0] S_SLOW = 4'h1;
  localparam [3:0] S_FAST_WAIT = 4'h2;
  localparam [3:0] S_FAST = 4'h4;
  localparam [3:0] S_SLOW_WAIT = 4'h8;

  function falling;
    input prev;
    input cur;
    begin
      falling = prev & ~cur;
    end
  endfunction

  function reg_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      reg_hit = (addr == offset);
    end
  endfunction

  wire is_dual = (CLOCK_CONFIG == `CFG_DUAL);
  wire is_fast_only = (CLOCK_CONFIG == `CFG_FAST_ONLY);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers; edges come from the second stage and its delayed copy
  reg slow_meta_reg;
  reg slow_sync_reg;
  reg slow_prev_reg;
  reg fast_meta_reg;
  reg fast_sync_reg;
  reg fast_prev_reg;

  always @(posedge clk) begin
    if (!resetn) begin
      slow_meta_reg <= 1'b0;
      slow_sync_reg <= 1'b0;
      slow_prev_reg <= 1'b0;
      fast_meta_reg <= 1'b0;
      fast_sync_reg <= 1'b0;
      fast_prev_reg <= 1'b0;
    end else begin
      slow_meta_reg <= slow_oscillator_clock;
      slow_sync_reg <= slow_meta_reg;
      slow_prev_reg <= slow_sync_reg;
      fast_meta_reg <= fast_oscillator_clock;
      fast_sync_reg <= fast_meta_reg;
      fast_prev_reg <= fast_sync_reg;
    end
  end

  wire slow_fall = falling(slow_prev_reg, slow_sync_reg);
  wire fast_fall = falling(fast_prev_reg, fast_sync_reg);

  //////////////////////////////////////////////////////////////////////////
  // source switch state machine
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [3:0] hold_cnt_reg;
  reg [3:0] hold_cnt_next;
  reg switch_done;
  wire to_slow = slow_instruction | halt_mode | stop_mode;

  always @* begin
    state_next = state_reg;
    hold_cnt_next = hold_cnt_reg;
    switch_done = 1'b0;
    case (state_reg)
      S_SLOW: begin
        // single builds treat the switch commands as a plain no-op
        if (is_dual && fast_instruction && !halt_mode && !stop_mode) begin
          state_next = S_FAST_WAIT;
          hold_cnt_next = 4'h0;
        end
      end
      S_FAST_WAIT: begin
        if (to_slow) begin
          state_next = S_SLOW_WAIT;
          hold_cnt_next = 4'h0;
        end else if (fast_fall) begin
          if (hold_cnt_reg == `FAST_HOLD_CYCLES - 4'h1) begin
            state_next = S_FAST;
            switch_done = 1'b1;
          end else begin
            hold_cnt_next = hold_cnt_reg + 4'h1;
          end
        end
      end
      S_FAST: begin
        if (to_slow) begin
          state_next = S_SLOW_WAIT;
          hold_cnt_next = 4'h0;
        end
      end
      S_SLOW_WAIT: begin
        if (slow_fall) begin
          if (hold_cnt_reg == `SLOW_HOLD_CYCLES - 4'h1) begin
            state_next = S_SLOW;
            switch_done = 1'b1;
          end else begin
            hold_cnt_next = hold_cnt_reg + 4'h1;
          end
        end
      end
      default: begin
        state_next = S_SLOW;
        hold_cnt_next = 4'h0;
      end
    endcase
  end

  wire holding = (state_next == S_FAST_WAIT) || (state_next == S_SLOW_WAIT);

  always @(posedge clk) begin
    if (!resetn) begin
      state_reg <= S_SLOW;
      hold_cnt_reg <= 4'h0;
      system_clock_reg <= 1'b0;
      system_clock_hold_reg <= 1'b0;
      slow_oscillator_enable_reg <= 1'b0;
      fast_oscillator_enable_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hold_cnt_reg <= hold_cnt_next;
      system_clock_hold_reg <= holding;
      // frozen during a hold, so no clipped pulse reaches the sequencer
      if (!holding) begin
        if (is_fast_only || (is_dual && state_next == S_FAST)) begin
          system_clock_reg <= fast_sync_reg;
        end else begin
          system_clock_reg <= slow_sync_reg;
        end
      end
      slow_oscillator_enable_reg <= !is_fast_only && !stop_mode;
      if (is_fast_only) begin
        fast_oscillator_enable_reg <= !stop_mode;
      end else begin
        fast_oscillator_enable_reg <= is_dual && !to_slow &&
          (state_next == S_FAST_WAIT || state_next == S_FAST);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pre-divider input clock: slow clock except in the fast-only build
  reg [2:0] fast_div_reg;

  always @(posedge clk) begin
    if (!resetn) begin
      fast_div_reg <= 3'h0;
      predivider_input_clock_reg <= 1'b0;
    end else begin
      if (fast_fall) begin
        fast_div_reg <= fast_div_reg + 3'h1;
      end
      if (!is_fast_only) begin
        predivider_input_clock_reg <= slow_sync_reg;
      end else begin
        case (PREDIV_INPUT_DIVIDE)
          `PREDIV_IN_DIV_1: predivider_input_clock_reg <= fast_sync_reg;
          `PREDIV_IN_DIV_4: predivider_input_clock_reg <= fast_div_reg[1];
          `PREDIV_IN_DIV_8: predivider_input_clock_reg <= fast_div_reg[2];
          default: predivider_input_clock_reg <= fast_div_reg[2] ^ fast_div_reg[0] ?
            predivider_input_clock_reg : predivider_input_clock_reg ^
            (fast_fall & (&fast_div_reg));
        endcase
      end
    end
  end

  reg input_prev_reg;

  always @(posedge clk) begin
    if (!resetn) begin
      input_prev_reg <= 1'b0;
    end else begin
      input_prev_reg <= predivider_input_clock_reg;
    end
  end

  wire [`PREDIV_STAGES-1:0] count_w;
  wire stage14_fall_w;
  wire clear_upper = pending_clear_instruction &&
                     (pending_clear_operand == `PENDING_CLEAR_OPERAND);

  predivider_counter #(
    .STAGES(`PREDIV_STAGES)
  ) predivider_counter_i (
    .clk(clk),
    .resetn(resetn),
    .input_fall(falling(input_prev_reg, predivider_input_clock_reg)),
    .clear_upper(clear_upper),
    .count_reg(count_w),
    .stage14_fall_reg(stage14_fall_w)
  );

  //////////////////////////////////////////////////////////////////////////
  // request flag, interrupt, halt release and start condition
  always @(posedge clk) begin
    if (!resetn) begin
      predivider_taps_reg <= {`PREDIV_STAGES{1'b0}};
      predivider_release_request_flag <= 1'b0;
      predivider_interrupt_request_reg <= 1'b0;
      halt_release_request_reg <= 1'b0;
      predivider_start_condition_flag <= 1'b0;
    end else begin
      predivider_taps_reg <= count_w;
      // an edge in the clearing cycle still leaves the flag set
      if (stage14_fall_w) begin
        predivider_release_request_flag <= 1'b1;
      end else if (request_flag_clear) begin
        predivider_release_request_flag <= 1'b0;
      end
      predivider_interrupt_request_reg <= stage14_fall_w &&
                                          predivider_interrupt_enable;
      halt_release_request_reg <= stage14_fall_w &&
                                  predivider_halt_release_enable;
      if (stage14_fall_w && predivider_halt_release_enable) begin
        predivider_start_condition_flag <= 1'b1;
      end else if (start_flag_clear) begin
        predivider_start_condition_flag <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb slave: no wait state, answer in the first access-phase cycle
  wire setup_phase = psel && !penable;
  wire access_done = psel && penable && pready;
  wire wr_en = access_done && pwrite;
  wire mapped = reg_hit(paddr, `REG_STATUS) || reg_hit(paddr, `REG_MASK) ||
                reg_hit(paddr, `REG_STATE) || reg_hit(paddr, `REG_BOOST) ||
                reg_hit(paddr, `REG_PREDIV);

  reg [`ST_WIDTH-1:0] status_reg;
  reg [`ST_WIDTH-1:0] status_next;
  reg [`ST_WIDTH-1:0] mask_reg;
  reg [`ST_WIDTH-1:0] events;
  reg [31:0] read_value;

  always @* begin
    events = {`ST_WIDTH{1'b0}};
    events[`ST_PREDIV_EVENT] = stage14_fall_w;
    events[`ST_HALT_RELEASE] = stage14_fall_w && predivider_halt_release_enable;
    events[`ST_SWITCH_DONE] = switch_done;
    status_next = status_reg;
    if (wr_en && reg_hit(paddr, `REG_STATUS)) begin
      status_next = status_reg & ~pwdata[`ST_WIDTH-1:0];
    end
    status_next = status_next | events;
  end

  always @* begin
    read_value = 32'h0000_0000;
    if (reg_hit(paddr, `REG_STATUS)) begin
      read_value[`ST_WIDTH-1:0] = status_reg;
    end else if (reg_hit(paddr, `REG_MASK)) begin
      read_value[`ST_WIDTH-1:0] = mask_reg;
    end else if (reg_hit(paddr, `REG_STATE)) begin
      read_value[`SV_FAST_SELECTED] = (state_reg == S_FAST);
      read_value[`SV_HOLDING] = system_clock_hold_reg;
      read_value[`SV_REQUEST_FLAG] = predivider_release_request_flag;
      read_value[`SV_START_FLAG] = predivider_start_condition_flag;
      read_value[`SV_BOOST] = oscillator_boost_flag;
      read_value[`SV_FAST_OSC_ON] = fast_oscillator_enable_reg;
      read_value[`SV_SLOW_OSC_ON] = slow_oscillator_enable_reg;
    end else if (reg_hit(paddr, `REG_BOOST)) begin
      read_value[0] = oscillator_boost_flag;
    end else if (reg_hit(paddr, `REG_PREDIV)) begin
      read_value[`PREDIV_STAGES-1:0] = predivider_taps_reg;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      status_reg <= `STATUS_RESET;
      mask_reg <= `MASK_RESET;
      oscillator_boost_flag <= BOOST_RESET;
      irq_reg <= 1'b0;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase && !mapped;
      prdata <= (setup_phase && !pwrite) ? read_value : 32'h0000_0000;
      status_reg <= status_next;
      if (wr_en && reg_hit(paddr, `REG_MASK)) begin
        mask_reg <= pwdata[`ST_WIDTH-1:0];
      end
      // restart at high drive wins over a software write in the same cycle
      if (!is_dual && stop_instruction) begin
        oscillator_boost_flag <= 1'b1;
      end else if (wr_en && reg_hit(paddr, `REG_BOOST)) begin
        oscillator_boost_flag <= pwdata[0];
      end
      irq_reg <= |(status_next & mask_reg);
    end
  end

endmodule

// *** clock_switch_checker_assertions.sv ***
// concurrent checks on the clock switch ports
`timescale 1ns/10ps
module clock_switch_checker (
  // clock and reset
  input wire clk,
  input wire resetn,
  // oscillators
  input wire slow_oscillator_clock,
  input wire fast_oscillator_clock,
  input wire slow_oscillator_enable_reg,
  input wire fast_oscillator_enable_reg,
  // core commands
  input wire fast_instruction,
  input wire slow_instruction,
  input wire halt_mode,
  input wire stop_mode,
  input wire pending_clear_instruction,
  input wire [11:0] pending_clear_operand,
  input wire predivider_interrupt_enable,
  // results
  input wire system_clock_reg,
  input wire system_clock_hold_reg,
  input wire [14:0] predivider_taps_reg,
  input wire predivider_release_request_flag,
  input wire predivider_interrupt_request_reg,
  input wire halt_release_request_reg,
  input wire predivider_start_condition_flag,
  // apb
  input wire psel,
  input wire penable,
  input wire pready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  reg [7:0] falls_reg;
  reg fast_d_reg;
  reg slow_d_reg;
  reg en_d_reg;
  reg [1:0] fast_f_reg;
  reg [1:0] slow_f_reg;
  // pin falls delayed two edges so they line up with the synchronised ones
  wire fall = fast_oscillator_enable_reg ? fast_f_reg[1] : slow_f_reg[1];
  always @(posedge clk) begin
    fast_d_reg <= fast_oscillator_clock;
    slow_d_reg <= slow_oscillator_clock;
    fast_f_reg <= {fast_f_reg[0], fast_d_reg & !fast_oscillator_clock};
    slow_f_reg <= {slow_f_reg[0], slow_d_reg & !slow_oscillator_clock};
    en_d_reg <= fast_oscillator_enable_reg;
    if (!system_clock_hold_reg || en_d_reg != fast_oscillator_enable_reg)
      falls_reg <= {7'h00, fall};
    else
      falls_reg <= falls_reg + {7'h00, fall};
  end
  a_hold_clock_static: assert property (system_clock_hold_reg && $past(system_clock_hold_reg)
    |-> $stable(system_clock_reg)) else $error("system clock moved during hold");
  a_fast_starts_hold: assert property (fast_instruction && !fast_oscillator_enable_reg
    && !system_clock_hold_reg && !halt_mode && !stop_mode
    |=> fast_oscillator_enable_reg && system_clock_hold_reg) else $error("fast switch not started");
  a_fast_hold_length: assert property ($fell(system_clock_hold_reg) && fast_oscillator_enable_reg
    |-> falls_reg == 8'h0c) else $error("fast hold length wrong");
  a_slow_hold_length: assert property ($fell(system_clock_hold_reg) && !fast_oscillator_enable_reg
    |-> falls_reg == 8'h02) else $error("slow hold length wrong");
  a_fast_osc_drop: assert property (fast_oscillator_enable_reg
    && (slow_instruction || halt_mode || stop_mode)
    |=> !fast_oscillator_enable_reg && system_clock_hold_reg) else $error("fast osc kept");
  a_stop_slow_off: assert property (stop_mode && $past(stop_mode)
    |-> !slow_oscillator_enable_reg) else $error("slow osc runs in stop");
  a_fall_sets_flag: assert property ($fell(predivider_taps_reg[13])
    |-> ##[0:3] predivider_release_request_flag) else $error("request flag not set");
  a_irq_pulse_cause: assert property (predivider_interrupt_request_reg
    |-> predivider_release_request_flag && $past(predivider_interrupt_enable)
    ##1 !predivider_interrupt_request_reg) else $error("bad interrupt pulse");
  a_release_start: assert property (halt_release_request_reg
    |-> predivider_start_condition_flag) else $error("start flag missing");
  a_clear_upper: assert property (pending_clear_instruction
    && pending_clear_operand == 12'h100
    |-> ##[1:2] predivider_taps_reg[14:10] == 5'h00) else $error("upper stages not cleared");
  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
endmodule

bind clock_switch clock_switch_checker clock_switch_checker_i (.clk(clk), .resetn(resetn),
  .slow_oscillator_clock(slow_oscillator_clock), .fast_oscillator_clock(fast_oscillator_clock),
  .slow_oscillator_enable_reg(slow_oscillator_enable_reg),
  .fast_oscillator_enable_reg(fast_oscillator_enable_reg),
  .fast_instruction(fast_instruction), .slow_instruction(slow_instruction),
  .halt_mode(halt_mode), .stop_mode(stop_mode),
  .pending_clear_instruction(pending_clear_instruction),
  .pending_clear_operand(pending_clear_operand),
  .predivider_interrupt_enable(predivider_interrupt_enable),
  .system_clock_reg(system_clock_reg), .system_clock_hold_reg(system_clock_hold_reg),
  .predivider_taps_reg(predivider_taps_reg),
  .predivider_release_request_flag(predivider_release_request_flag),
  .predivider_interrupt_request_reg(predivider_interrupt_request_reg),
  .halt_release_request_reg(halt_release_request_reg),
  .predivider_start_condition_flag(predivider_start_condition_flag),
  .psel(psel), .penable(penable), .pready(pready));

// *** osc_model.sv ***
// behavioural oscillator feeding one clock switch pin
`timescale 1ns/10ps
module osc_model #(
  parameter HALF = 3
) (
  // clock and enable
  input wire clk,
  input wire enable,
  // oscillator pin
  output reg pin
);
  integer cnt = 0;
  initial pin = 1'b0;
  // a stopped oscillator rests low, no stray edge
  always @(posedge clk) begin
    if (!enable) begin
      cnt <= 0;
      pin <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      pin <= !pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// *** clock_switch_bench.sv ***
// self-checking bench for the dual clock switch
`timescale 1ns/10ps
`include "clock_switch_map.vh"
module clock_switch_bench;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg halt_mode = 1'b0;
  reg stop_mode = 1'b0;
  reg predivider_interrupt_enable = 1'b0;
  reg predivider_halt_release_enable = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [11:0] pending_clear_operand = 12'h000;
  reg [31:0] pwdata = 32'h0000_0000;
  reg [5:0] cmd = 6'h00;
  reg [31:0] r;
  reg [32:0] exp_word;
  reg [32:0] rq[$];
  integer num_errors = 0;
  integer samples_checked = 0;
  wire slow_oscillator_clock, fast_oscillator_clock, system_clock_reg, system_clock_hold_reg;
  wire slow_oscillator_enable_reg, fast_oscillator_enable_reg, predivider_input_clock_reg;
  wire predivider_release_request_flag, predivider_interrupt_request_reg, irq_reg;
  wire halt_release_request_reg, predivider_start_condition_flag, oscillator_boost_flag;
  wire pready, pslverr;
  wire [14:0] predivider_taps_reg;
  wire [31:0] prdata;
  wire fast_instruction = cmd[0];
  wire slow_instruction = cmd[1];
  wire stop_instruction = cmd[2];
  wire pending_clear_instruction = cmd[3];
  wire request_flag_clear = cmd[4];
  wire start_flag_clear = cmd[5];

  always #4 clk = ~clk;

  clock_switch clock_switch_i (.clk, .resetn, .slow_oscillator_clock, .fast_oscillator_clock,
    .slow_oscillator_enable_reg, .fast_oscillator_enable_reg, .fast_instruction,
    .slow_instruction, .stop_instruction, .halt_mode, .stop_mode, .pending_clear_instruction,
    .pending_clear_operand, .predivider_interrupt_enable, .predivider_halt_release_enable,
    .request_flag_clear, .start_flag_clear, .system_clock_reg, .system_clock_hold_reg,
    .predivider_input_clock_reg, .predivider_taps_reg, .predivider_release_request_flag,
    .predivider_interrupt_request_reg, .halt_release_request_reg,
    .predivider_start_condition_flag, .oscillator_boost_flag, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .irq_reg);
  osc_model #(.HALF(3)) slow_osc_i (.clk, .enable(slow_oscillator_enable_reg),
    .pin(slow_oscillator_clock));
  osc_model #(.HALF(2)) fast_osc_i (.clk, .enable(fast_oscillator_enable_reg),
    .pin(fast_oscillator_clock));

  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    begin
      $display("counts: %0d mismatches, %0d checks", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  task chk(input [32:0] got, input [32:0] want, input string m);
    begin
      samples_checked = samples_checked + 1;
      if (got !== want) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: %s got %h want %h", $time, m, got, want);
      end
    end
  endtask

  task tmo;
    begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: wait ran out", $time);
      stop_test;
    end
  endtask

  function pick(input [1:0] s);
    case (s)
      2'h0: pick = system_clock_hold_reg;
      2'h1: pick = predivider_taps_reg[13];
      2'h2: pick = predivider_release_request_flag;
      default: pick = irq_reg;
    endcase
  endfunction

  task waitv(input [1:0] s, input v, input integer lim);
    integer n;
    begin
      n = 0;
      while (pick(s) !== v && n < lim) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n >= lim) tmo;
    end
  endtask

  // reads note their expected {pslverr, prdata} for the monitor
  task apb(input w, input [11:0] a, input [31:0] d, input [32:0] e);
    integer n;
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) rq.push_back(e);
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) tmo;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task pulse(input [5:0] c);
    begin
      @(posedge clk);
      cmd <= c;
      @(posedge clk);
      cmd <= 6'h00;
    end
  endtask

  task switch_to(input [5:0] c);
    begin
      pulse(c);
      waitv(2'h0, 1'b1, 10);
      waitv(2'h0, 1'b0, 2000);
    end
  endtask

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      exp_word = rq.pop_front();
      chk({pslverr, prdata}, exp_word, "read data");
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    r = $urandom(63607);
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, `REG_STATE, 32'h0000_0000, 33'h0_0000_0050);
    apb(1'b0, 12'h020, 32'h0000_0000, 33'h1_0000_0000);
    $display("test reset done");
    repeat ($urandom % 8) @(posedge clk);
    switch_to(6'h01);
    apb(1'b0, `REG_STATE, 32'h0000_0000, 33'h0_0000_0071);
    apb(1'b0, `REG_STATUS, 32'h0000_0000, 33'h0_0000_0004);
    apb(1'b1, `REG_STATUS, 32'h0000_0004, 33'h0_0000_0000);
    @(posedge clk);
    halt_mode <= 1'b1;
    waitv(2'h0, 1'b1, 10);
    chk({32'h0, fast_oscillator_enable_reg}, 33'h0_0000_0000, "fast osc in halt");
    waitv(2'h0, 1'b0, 200);
    halt_mode <= 1'b0;
    apb(1'b0, `REG_STATE, 32'h0000_0000, 33'h0_0000_0050);
    $display("test halt revert done");
    switch_to(6'h01);
    pulse(6'h02);
    waitv(2'h0, 1'b1, 10);
    chk({32'h0, fast_oscillator_enable_reg}, 33'h0_0000_0000, "fast osc off");
    waitv(2'h0, 1'b0, 200);
    apb(1'b0, `REG_STATE, 32'h0000_0000, 33'h0_0000_0050);
    $display("test slow switch done");
    r = $urandom % 2;
    apb(1'b1, `REG_BOOST, r, 33'h0_0000_0000);
    apb(1'b0, `REG_BOOST, 32'h0000_0000, {1'b0, r});
    $display("test boost done");
    apb(1'b1, `REG_STATUS, 32'h0000_0007, 33'h0_0000_0000);
    apb(1'b1, `REG_MASK, 32'h0000_0001, 33'h0_0000_0000);
    predivider_interrupt_enable <= 1'b1;
    predivider_halt_release_enable <= 1'b1;
    waitv(2'h1, 1'b1, 60000);
    pending_clear_operand <= 12'h0ff & $urandom;
    pulse(6'h08);
    repeat (2) @(posedge clk);
    chk({32'h0, predivider_taps_reg[13]}, 33'h0_0000_0001, "stage kept");
    pending_clear_operand <= 12'h100;
    pulse(6'h08);
    waitv(2'h2, 1'b1, 10);
    repeat (2) @(posedge clk);
    chk({32'h0, predivider_start_condition_flag}, 33'h0_0000_0001, "start flag");
    chk({28'h0, predivider_taps_reg[14:10]}, 33'h0_0000_0000, "upper stages");
    waitv(2'h3, 1'b1, 10);
    apb(1'b0, `REG_STATUS, 32'h0000_0000, 33'h0_0000_0003);
    apb(1'b1, `REG_STATUS, 32'h0000_0003, 33'h0_0000_0000);
    waitv(2'h3, 1'b0, 10);
    pulse(6'h30);
    repeat (2) @(posedge clk);
    chk({31'h0, predivider_release_request_flag, predivider_start_condition_flag},
        33'h0_0000_0000, "flags cleared");
    $display("test pre-divider done");
    pulse(6'h04);
    stop_mode <= 1'b1;
    repeat (3) @(posedge clk);
    chk({32'h0, slow_oscillator_enable_reg}, 33'h0_0000_0000, "slow osc in stop");
    stop_mode <= 1'b0;
    $display("test stop done");
    stop_test;
  end
endmodule
